/* File: src/scwp_sysctl.v */
// system control, strap configuration, watchdog and pin select registers
`timescale 1ns/10ps
`default_nettype none
`include "scwp_sysctl_regs.vh"

module scwp_sysctl #(
  parameter [7:0] DEVICE_CODE   = 8'h5A,  // arbitrary value
  parameter [7:0] REVISION_CODE = 8'h01   // arbitrary value
) (
  input  wire        core_clk,
  input  wire        rst,
  // processor register port
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [31:0] reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_rdy,
  // pins sampled from outside
  input  wire [6:0]  config_strap_pins,
  input  wire        test_pin,
  // strap derived settings
  output reg         cfg_ready,
  output wire        clock_select_pll,
  output wire        test_mode_active,
  output wire [2:0]  test_mode_sel,
  output wire        scan_download_active,
  output wire [1:0]  boot_rom_width,
  output wire        local_bus_32,
  output wire        upper_data_as_gpio,
  // system wait controls
  output wire [1:0]  exp_rom_width,
  output wire [2:0]  frame_wait_clks,
  output wire [2:0]  reg_wait_clks,
  output wire [4:0]  strobe_width_clks,
  // watchdog
  output reg         wdog_chip_reset,
  // pin functions: 00 primary, 01 gpio, 10 alternate, 11 scan
  output wire [7:0]  address_gpio_sel,
  output wire [1:0]  pin_a27_func,
  output wire [1:0]  pin_dma_request_0_func,
  output wire [1:0]  pin_dma_acknowledge_0_func,
  output wire [1:0]  pin_dma_request_1_func,
  output wire [1:0]  pin_dma_acknowledge_1_func,
  output wire [1:0]  pin_dtc_func,
  output wire        pin_sel5_alt,
  output wire        pin_pwm_alt,
  output wire        pin_irq1_alt,
  output wire        pin_irq2_alt,
  output wire        pin_uart1_transmit_enable_alt,
  output wire [8:0]  pin_single_alt
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // two-bit mux code: 00 primary, 01 gpio, 1x alternate
  function [1:0] pm_func;
    input [1:0] code;
    begin
      pm_func = code[1] ? 2'h2 : {1'b0, code[0]};
    end
  endfunction

  // bus width code: 00 8 bit, 01 16 bit, 1x 32 bit
  function [1:0] width_code;
    input [1:0] code;
    begin
      width_code = code[1] ? 2'h2 : code;
    end
  endfunction

  // wait code 00..11 gives 2..5 clocks
  function [2:0] wait_clks;
    input [1:0] code;
    begin
      wait_clks = {1'b0, code} + 3'h2;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // strap capture

  reg  [6:0] strap_meta;
  reg  [6:0] strap_sync;
  reg        test_meta;
  reg        test_sync;
  reg        rst_q;
  reg  [6:0] strap_cfg;

  // synchronisers keep running through reset so the straps are settled
  // by the time reset is released
  // no reset on these flops: they only copy the pins
  always @(posedge core_clk) begin
    strap_meta <= config_strap_pins;
    strap_sync <= strap_meta;
    test_meta  <= test_pin;
    test_sync  <= test_meta;
  end

  // straps are taken only on power-on release; a watchdog reset keeps them
  always @(posedge core_clk) begin
    if (rst) begin
      rst_q     <= 1'b1;
      strap_cfg <= 7'h00;
      cfg_ready <= 1'b0;
    end else begin
      rst_q <= 1'b0;
      if (rst_q) begin
        strap_cfg <= strap_sync;
        cfg_ready <= 1'b1;
      end
    end
  end

  // the capture edge is the first one with rst low; everything built from
  // strap_cfg reads zero until then (upper_data_as_gpio reads one), so nothing downstream may trust it
  // before cfg_ready
  assign clock_select_pll     = strap_cfg[`SCWP_CFG_CLKSEL_BIT];
  assign test_mode_sel        = strap_cfg[5:3];
  assign test_mode_active     = test_sync;
  // scan only serves the download path over the dma pin group; frame and
  // texture memory pins are never switched by it
  assign scan_download_active = test_sync &
                                (strap_cfg[5:4] == 2'h3);
  assign boot_rom_width       = width_code(strap_cfg[2:1]);
  assign local_bus_32         = strap_cfg[0];
  assign upper_data_as_gpio   = ~strap_cfg[0];

  //////////////////////////////////////////////////////////////////////////
  // register decode

  // decode is exact on the full byte address, so any other offset in the
  // block window reads zero and drops writes
  wire sel_ident = (reg_addr == `SCWP_ADDR_IDENTITY);
  wire sel_cfg   = (reg_addr == `SCWP_ADDR_STRAP_CFG);
  wire sel_wait  = (reg_addr == `SCWP_ADDR_WAIT_CTRL);
  wire sel_wctl  = (reg_addr == `SCWP_ADDR_WDOG_CTRL);
  wire sel_wcnt  = (reg_addr == `SCWP_ADDR_WDOG_COUNT);
  wire sel_pin1  = (reg_addr == `SCWP_ADDR_PIN_SEL1);
  wire sel_pin2  = (reg_addr == `SCWP_ADDR_PIN_SEL2);

  wire wr_wait = reg_wr & sel_wait;
  wire wr_wctl = reg_wr & sel_wctl;
  wire wr_wcnt = reg_wr & sel_wcnt;
  wire wr_pin1 = reg_wr & sel_pin1;
  wire wr_pin2 = reg_wr & sel_pin2;
  wire rd_wctl = reg_rd & sel_wctl;

  //////////////////////////////////////////////////////////////////////////
  // control registers

  reg  [9:0]  wait_ctrl;
  reg         wdog_en;
  reg  [2:0]  wdog_pre;
  reg         wdog_status;
  reg  [31:0] pin_sel1;
  reg  [31:0] pin_sel2;
  reg  [15:0] wdog_count;
  reg  [14:0] pre_cnt;
  reg  [14:0] pulse_cnt;

  // only the field bits are kept; bit 3 and the upper bits read back as
  // zero whatever was written
  wire [31:0] wait_wdata = reg_wdata & `SCWP_WAIT_WMASK;
  // an enable write while the timer is off starts a fresh prescale period
  wire        wdog_enabling = wr_wctl & reg_wdata[`SCWP_WDOG_EN_BIT] &
                              ~wdog_en;
  wire [14:0] pre_period = `SCWP_PRESCALE_BASE << wdog_pre;
  wire        pre_tick   = wdog_en & (pre_cnt == pre_period - 15'h0001);
  wire        wdog_fire  = pre_tick & (wdog_count <= 16'h0001) &
                           ~wdog_chip_reset;
  // the watchdog pulse puts the control state back to its defaults
  // writes that arrive during the pulse are lost
  wire        soft_rst   = rst | wdog_chip_reset;

  always @(posedge core_clk) begin
    if (soft_rst) begin
      wait_ctrl <= `SCWP_WAIT_RESET;
      wdog_en   <= 1'b0;
      wdog_pre  <= `SCWP_WDOG_PRE_RESET;
      pin_sel1  <= `SCWP_PIN_RESET;
      pin_sel2  <= `SCWP_PIN_RESET;
    end else begin
      if (wr_wait) begin
        wait_ctrl <= wait_wdata[9:0];
      end
      if (wr_wctl) begin
        wdog_en  <= reg_wdata[`SCWP_WDOG_EN_BIT];
        wdog_pre <= reg_wdata[3:1];
      end
      if (wr_pin1) begin
        pin_sel1 <= reg_wdata & `SCWP_PIN1_WMASK;
      end
      if (wr_pin2) begin
        pin_sel2 <= reg_wdata & `SCWP_PIN2_WMASK;
      end
    end
  end

  // status survives the watchdog pulse; only power-on clears it
  always @(posedge core_clk) begin
    if (rst) begin
      wdog_status <= 1'b0;
    end else if (wdog_fire) begin
      wdog_status <= 1'b1;
    end
  end

  assign exp_rom_width     = width_code(wait_ctrl[9:8]);
  assign frame_wait_clks   = wait_clks(wait_ctrl[7:6]);
  assign reg_wait_clks     = wait_clks(wait_ctrl[5:4]);
  // strobe width is twice the code plus two, 2 to 16 clocks
  assign strobe_width_clks = {1'b0, wait_ctrl[2:0], 1'b0} + 5'h02;

  //////////////////////////////////////////////////////////////////////////
  // watchdog

  // the prescaler ticks once per 128 << pre cycles, each tick takes one
  // off the count, and the tick that finds one or zero left raises the
  // chip reset on the next edge. software must service the timer with a
  // count write, never a control read: the read empties the count and
  // lets the next tick fire
  // prescaler restarts whenever the enable goes from off to on
  always @(posedge core_clk) begin
    if (soft_rst) begin
      pre_cnt <= 15'h0000;
    end else if (~wdog_en | wdog_enabling) begin
      pre_cnt <= 15'h0000;
    end else if (pre_tick | (pre_cnt >= pre_period)) begin
      // a smaller period written mid-count wraps at once
      pre_cnt <= 15'h0000;
    end else begin
      pre_cnt <= pre_cnt + 15'h0001;
    end
  end

  // a software write wins over a tick in the same cycle; a read of the
  // control register zeroes the count, which expires on the next tick
  always @(posedge core_clk) begin
    if (soft_rst) begin
      wdog_count <= `SCWP_WDOG_CNT_RESET;
    end else if (wr_wcnt) begin
      wdog_count <= reg_wdata[15:0];
    end else if (rd_wctl) begin
      wdog_count <= 16'h0000;
    end else if (pre_tick & (wdog_count != 16'h0000)) begin
      wdog_count <= wdog_count - 16'h0001;
    end
  end

  // reset pulse lasts one prescale period at the setting in force
  // it has its own counter because the prescaler is held in reset along
  // with the rest of the control state and cannot time the pulse itself
  always @(posedge core_clk) begin
    if (rst) begin
      wdog_chip_reset <= 1'b0;
      pulse_cnt       <= 15'h0000;
    end else if (wdog_fire) begin
      wdog_chip_reset <= 1'b1;
      pulse_cnt       <= pre_period - 15'h0001;
    end else if (wdog_chip_reset) begin
      if (pulse_cnt == 15'h0000) begin
        wdog_chip_reset <= 1'b0;
      end else begin
        pulse_cnt <= pulse_cnt - 15'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin multiplexing

  // the function codes are a local convention: 00 primary, 01 gpio,
  // 10 alternate, 11 scan; only the dma group can ever show 11
  assign address_gpio_sel = pin_sel1[20:13];
  assign pin_a27_func     = pm_func(pin_sel1[11:10]);
  // scan download takes the dma group over whatever the mux holds
  assign pin_dma_request_0_func   = scan_download_active ? 2'h3 :
                            pm_func(pin_sel1[9:8]);
  assign pin_dma_acknowledge_0_func   = scan_download_active ? 2'h3 :
                            pm_func(pin_sel1[7:6]);
  assign pin_dma_request_1_func   = scan_download_active ? 2'h3 :
                            pm_func(pin_sel1[5:4]);
  assign pin_dma_acknowledge_1_func   = scan_download_active ? 2'h3 :
                            pm_func(pin_sel1[3:2]);
  assign pin_dtc_func     = scan_download_active ? 2'h3 :
                            pm_func(pin_sel1[1:0]);

  assign pin_sel5_alt     = pin_sel2[18];
  assign pin_pwm_alt      = pin_sel2[13];
  assign pin_irq1_alt     = pin_sel2[11];
  assign pin_irq2_alt     = pin_sel2[9];
  assign pin_uart1_transmit_enable_alt    = pin_sel2[3];
  // bit order: 21,19,16,7,6,5,4,1,0
  assign pin_single_alt   = {pin_sel2[21], pin_sel2[19], pin_sel2[16],
                             pin_sel2[7:4], pin_sel2[1],
                             pin_sel2[0]};

  //////////////////////////////////////////////////////////////////////////
  // read path

  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    if (sel_ident) begin
      next_rdata = {16'h0000, DEVICE_CODE, REVISION_CODE};
    end else if (sel_cfg) begin
      next_rdata = {25'h0000000, strap_cfg};
    end else if (sel_wait) begin
      next_rdata = {22'h000000, wait_ctrl};
    end else if (sel_wctl) begin
      next_rdata = {27'h0000000, wdog_status, wdog_pre,
                    wdog_en};
    end else if (sel_wcnt) begin
      next_rdata = {16'h0000, wdog_count};
    end else if (sel_pin1) begin
      next_rdata = pin_sel1;
    end else if (sel_pin2) begin
      next_rdata = pin_sel2;
    end
  end

  // every access is answered one cycle later; unmapped ones read zero
  // reg_rdata only moves on reads, so a write in between leaves the last
  // read value standing for a master that samples late
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_rdy   <= 1'b0;
    end else begin
      reg_rdy <= reg_rd | reg_wr;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule // scwp_sysctl

`default_nettype wire

/* File: src/scwp_sysctl_regs.vh */
// register offsets, field positions, reset values and counts for scwp_sysctl
`ifndef SCWP_SYSCTL_REGS_VH
`define SCWP_SYSCTL_REGS_VH

`define SCWP_ADDR_IDENTITY   32'h01800000
`define SCWP_ADDR_STRAP_CFG  32'h01800004
`define SCWP_ADDR_WAIT_CTRL  32'h01800008
`define SCWP_ADDR_WDOG_CTRL  32'h01800010
`define SCWP_ADDR_WDOG_COUNT 32'h01800014
`define SCWP_ADDR_PIN_SEL1   32'h01800018
`define SCWP_ADDR_PIN_SEL2   32'h0180001C

`define SCWP_CFG_CLKSEL_BIT  6
`define SCWP_WAIT_WMASK      32'h000003F7
`define SCWP_WAIT_RESET      10'h0F7
`define SCWP_WDOG_EN_BIT     0
`define SCWP_WDOG_STAT_BIT   4
`define SCWP_WDOG_PRE_RESET  3'h7
`define SCWP_WDOG_CNT_RESET  16'hFFFF
`define SCWP_PIN1_WMASK      32'h001FEFFF
`define SCWP_PIN2_WMASK      32'h002F3FFF
`define SCWP_PIN_RESET       32'h00000000
`define SCWP_PRESCALE_BASE   15'h0080

`endif

/* File: verif/scwp_sysctl_assertions.sv */
// concurrent checks on the system control block ports
`timescale 1ns/10ps
`default_nettype none
`include "scwp_sysctl_regs.vh"
module scwp_sysctl_assertions (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rdy,
  input wire logic        cfg_ready,
  input wire logic        clock_select_pll,
  input wire logic        test_mode_active,
  input wire logic [2:0]  test_mode_sel,
  input wire logic        scan_download_active,
  input wire logic [1:0]  boot_rom_width,
  input wire logic        local_bus_32,
  input wire logic        upper_data_as_gpio,
  input wire logic [1:0]  exp_rom_width,
  input wire logic [2:0]  frame_wait_clks,
  input wire logic [2:0]  reg_wait_clks,
  input wire logic [4:0]  strobe_width_clks,
  input wire logic        wdog_chip_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // writes landing while the watchdog holds reset are dropped on purpose
  wire wait_wr = reg_wr && reg_addr == `SCWP_ADDR_WAIT_CTRL &&
                 !wdog_chip_reset;
  wire ctl_rd = reg_rd && reg_addr == `SCWP_ADDR_WDOG_CTRL && !wdog_chip_reset;
  wire cnt_rd = reg_rd && reg_addr == `SCWP_ADDR_WDOG_COUNT &&
                !wdog_chip_reset;
  ////////////////////////////////////////////////////////////////////////////
  a_ready_after_req: assert property ((reg_rd || reg_wr) |=> reg_rdy)
    else $error("ready missing after request");
  a_ready_no_req: assert property (!(reg_rd || reg_wr) |=> !reg_rdy)
    else $error("ready without request");
  a_upper_data_gpio: assert property (
    cfg_ready |-> upper_data_as_gpio == !local_bus_32)
    else $error("upper data gpio mismatch");
  a_scan_mode_decode: assert property (
    cfg_ready |-> scan_download_active ==
      (test_mode_active && test_mode_sel[2:1] == 2'b11))
    else $error("scan mode decode wrong");
  a_straps_held: assert property (
    cfg_ready && $past(cfg_ready) |->
      $stable({clock_select_pll, test_mode_sel, boot_rom_width, local_bus_32}))
    else $error("strap settings changed");
  a_exp_rom_width: assert property (wait_wr |=> exp_rom_width ==
    ($past(reg_wdata[9]) ? 2'd2 : $past(reg_wdata[9:8])))
    else $error("expansion width wrong");
  a_wait_fields: assert property (wait_wr |=>
    frame_wait_clks == {1'b0, $past(reg_wdata[7:6])} + 3'd2 &&
    reg_wait_clks == {1'b0, $past(reg_wdata[5:4])} + 3'd2)
    else $error("wait cycles wrong");
  a_strobe_width: assert property (wait_wr |=>
    strobe_width_clks == {1'b0, $past(reg_wdata[2:0]), 1'b0} + 5'd2)
    else $error("strobe width wrong");
  a_ctrl_read_clear: assert property (
    ctl_rd ##1 cnt_rd |=> reg_rdata[15:0] == 16'h0000)
    else $error("count not cleared by control read");
  a_reset_min_width: assert property (
    $rose(wdog_chip_reset) |-> wdog_chip_reset [*8])
    else $error("watchdog reset too short");
endmodule // scwp_sysctl_assertions

bind scwp_sysctl scwp_sysctl_assertions i_chk (
  .core_clk(core_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rdy(reg_rdy), .cfg_ready(cfg_ready),
  .clock_select_pll(clock_select_pll), .test_mode_active(test_mode_active),
  .test_mode_sel(test_mode_sel), .scan_download_active(scan_download_active),
  .boot_rom_width(boot_rom_width), .local_bus_32(local_bus_32),
  .upper_data_as_gpio(upper_data_as_gpio), .exp_rom_width(exp_rom_width),
  .frame_wait_clks(frame_wait_clks), .reg_wait_clks(reg_wait_clks),
  .strobe_width_clks(strobe_width_clks), .wdog_chip_reset(wdog_chip_reset)
);
`default_nettype wire

/* File: verif/scwp_cpu_model.sv */
// processor side register master for the system control block
`timescale 1ns/10ps
`default_nettype none
module scwp_cpu_model (
  input  wire logic        core_clk,
  output var  logic        reg_rd,
  output var  logic        reg_wr,
  output var  logic [31:0] reg_addr,
  output var  logic [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rdy
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 32'h00000000;
    reg_wdata = 32'h00000000;
  end
  // entered just after an edge; keep leaves the strobe up so the next call
  // follows back to back without a second assignment in one time step
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] d,
                      input logic keep);
    integer n;
    begin
      reg_rd = !w;
      reg_wr = w;
      reg_addr = a;
      reg_wdata = wd;
      @(posedge core_clk);
      #1;
      if (!keep) begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
      end
      n = 0;
      while (reg_rdy !== 1'b1 && n < 4) begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      if (n == 4) begin
        tb.bad_count = tb.bad_count + 1;
        tb.end_of_test;
      end
      d = reg_rdata;
      // a released strobe is left low over one edge before the next call
      if (!keep) begin
        @(posedge core_clk);
        #1;
      end
    end
  endtask
endmodule // scwp_cpu_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the system control register block
`timescale 1ns/10ps
`default_nettype none
`include "scwp_sysctl_regs.vh"
module tb;
  localparam [7:0]  DEV = 8'h3C; // arbitrary value
  localparam [7:0]  REV = 8'h02; // arbitrary value
  localparam [31:0] ID  = {16'h0000, DEV, REV};
  localparam [31:0] ONE = 32'hFFFFFFFF;
  logic        core_clk, rst, test_pin;
  logic [6:0]  straps;
  wire         reg_rd, reg_wr, reg_rdy, cfg_ready, pll, scan, lb32, ugpio;
  wire         wrst, tact;
  wire  [5:0]  dmid;
  wire  [31:0] reg_addr, reg_wdata, reg_rdata;
  wire  [2:0]  tsel, fwait, rwait;
  wire  [1:0]  boot, exp_w, a27, dma_request_0, dma_terminal_count;
  wire  [4:0]  strobe, alt2;
  wire  [7:0]  agpio;
  wire  [8:0]  single;
  integer      bad_count, check_count, i, n, w;
  logic [1:0]  c;
  logic [31:0] d;
  logic [127:0] rows [0:7];
  wire  [9:0]  strap_view = {cfg_ready, pll, tsel, scan, boot, lb32, ugpio};
  wire  [12:0] wait_view  = {exp_w, fwait, rwait, strobe};
  wire  [27:0] pin_view   = {agpio, a27, dma_request_0, dma_terminal_count, alt2, single};
  scwp_sysctl #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) i_dut (
    .core_clk(core_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdy(reg_rdy), .config_strap_pins(straps), .test_pin(test_pin),
    .cfg_ready(cfg_ready), .clock_select_pll(pll), .test_mode_active(tact),
    .test_mode_sel(tsel), .scan_download_active(scan),
    .boot_rom_width(boot), .local_bus_32(lb32), .upper_data_as_gpio(ugpio),
    .exp_rom_width(exp_w), .frame_wait_clks(fwait), .reg_wait_clks(rwait),
    .strobe_width_clks(strobe), .wdog_chip_reset(wrst),
    .address_gpio_sel(agpio), .pin_a27_func(a27), .pin_dma_request_0_func(dma_request_0),
    .pin_dma_acknowledge_0_func(dmid[5:4]), .pin_dma_request_1_func(dmid[3:2]),
    .pin_dma_acknowledge_1_func(dmid[1:0]),
    .pin_dtc_func(dma_terminal_count), .pin_sel5_alt(alt2[4]), .pin_pwm_alt(alt2[3]),
    .pin_irq1_alt(alt2[2]), .pin_irq2_alt(alt2[1]),
    .pin_uart1_transmit_enable_alt(alt2[0]), .pin_single_alt(single));
  scwp_cpu_model i_cpu (.core_clk(core_clk), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rdy(reg_rdy));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, want);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // cycles until the watchdog reset rises, then how long it stays up
  task pulse(input integer lim);
    begin
      n = 0;
      w = 0;
      while (wrst !== 1'b1 && n < lim) begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      while (wrst === 1'b1 && w < lim) begin
        @(posedge core_clk);
        #1;
        w = w + 1;
      end
      if (n >= lim || w >= lim) begin
        bad_count = bad_count + 1;
        end_of_test;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    bad_count = 0;
    check_count = 0;
    rows = '{{`SCWP_ADDR_IDENTITY, ONE, ID, ID},
      {`SCWP_ADDR_STRAP_CFG, ONE, 32'h00000076, 32'h00000076},
      {`SCWP_ADDR_WAIT_CTRL, ONE, 32'h000000F7, 32'h000003F7},
      {`SCWP_ADDR_PIN_SEL1, ONE, 32'h00000000, 32'h001FEFFF},
      {`SCWP_ADDR_PIN_SEL2, ONE, 32'h00000000, 32'h002F3FFF},
      {32'h0180000C, ONE, 32'h00000000, 32'h00000000},
      {`SCWP_ADDR_WDOG_COUNT, 32'h12345678, 32'h0000FFFF, 32'h00005678},
      {`SCWP_ADDR_WDOG_CTRL, 32'h0000001E, 32'h0000000E, 32'h0000000E}};
    straps = 7'h76;
    test_pin = 1'b1;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 straps = 7'h0B;
    chk(strap_view, 32'h000003D9);
    for (i = 0; i < 8; i = i + 1) begin
      i_cpu.xfer(1'b0, rows[i][127:96], 32'h0, d, 1'b0);
      chk(d, rows[i][63:32]);
      i_cpu.xfer(1'b1, rows[i][127:96], rows[i][95:64], d, 1'b0);
      i_cpu.xfer(1'b0, rows[i][127:96], 32'h0, d, 1'b0);
      chk(d, rows[i][31:0]);
    end
    chk(pin_view, 32'h0FFBFFFF);
    chk({tact, dmid}, 32'h0000007F);
    // second power-on reset with the test pin off recaptures the straps
    rst = 1'b1;
    test_pin = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(strap_view, 32'h00000226);
    for (i = 0; i < 8; i = i + 1) begin
      c = i[1:0];
      i_cpu.xfer(1'b1, `SCWP_ADDR_WAIT_CTRL,
                 {22'h0, c, c, c, 1'b0, i[2:0]}, d, 1'b0);
      chk(wait_view, {(c[1] ? 2'd2 : c),
          {1'b0, c} + 3'd2, {1'b0, c} + 3'd2, {1'b0, i[2:0], 1'b0} + 5'd2});
    end
    for (i = 0; i < 3; i = i + 1) begin
      c = i[1:0];
      i_cpu.xfer(1'b1, `SCWP_ADDR_PIN_SEL1,
                 {11'h0, {8{c[0]}}, 1'b0, c, c, c, c, c, c}, d, 1'b0);
      i_cpu.xfer(1'b1, `SCWP_ADDR_PIN_SEL2, {10'h0, c[0], 1'b0, c[0], c, c[0],
                 2'b00, c, c, c, {4{c[0]}}, c, c[0], c[0]}, d, 1'b0);
      chk(pin_view, {{8{c[0]}},
          {3{c[1] ? 2'b10 : c}}, {5{c[1]}}, {9{c[0]}}});
      chk({tact, dmid}, {1'b0, {3{c[1] ? 2'b10 : c}}});
    end
    i_cpu.xfer(1'b1, `SCWP_ADDR_WDOG_COUNT, 32'h00000002, d, 1'b0);
    i_cpu.xfer(1'b1, `SCWP_ADDR_WDOG_CTRL, 32'h00000001, d, 1'b0);
    repeat (150) @(posedge core_clk);
    #1;
    i_cpu.xfer(1'b0, `SCWP_ADDR_WDOG_COUNT, 32'h0, d, 1'b0);
    chk(d, 32'h00000001);
    pulse(400);
    chk(n >= 100 && n <= 110, 32'h1);
    chk(w, 32'd128);
    i_cpu.xfer(1'b0, `SCWP_ADDR_WDOG_COUNT, 32'h0, d, 1'b0);
    chk(d, 32'h0000FFFF);
    i_cpu.xfer(1'b0, `SCWP_ADDR_WDOG_CTRL, 32'h0, d, 1'b0);
    chk(d, 32'h0000001E);
    chk(wait_view, 32'h000005B0);
    // longest prescale with the count emptied by a control read
    i_cpu.xfer(1'b1, `SCWP_ADDR_WDOG_CTRL, 32'h0000000F, d, 1'b0);
    i_cpu.xfer(1'b0, `SCWP_ADDR_WDOG_CTRL, 32'h0, d, 1'b1);
    i_cpu.xfer(1'b0, `SCWP_ADDR_WDOG_COUNT, 32'h0, d, 1'b0);
    chk(d, 32'h00000000);
    pulse(17000);
    chk(n >= 16375 && n <= 16392, 32'h1);
    chk(w, 32'd16384);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
